// ### rtl/bfs_defines.vh
`ifndef BFS_DEFINES_VH
`define BFS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define BFS_OFS_CTRL      8'h00
`define BFS_OFS_TIME      8'h04
`define BFS_OFS_THRESH    8'h08
`define BFS_OFS_STATUS    8'h0C
`define BFS_OFS_IRQ_STAT  8'h10
`define BFS_OFS_IRQ_MASK  8'h14
`define BFS_OFS_ACK       8'h18

// ----------------------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------------------
`define BFS_CTRL_ENABLE   0
`define BFS_CTRL_SCH_LO   1
`define BFS_CTRL_SCH_HI   2
`define BFS_CTRL_TRG_LO   3
`define BFS_CTRL_TRG_HI   4
`define BFS_CTRL_XEN_LO   5
`define BFS_CTRL_XEN_HI   7

// Supervision schemes.
`define BFS_SCH_CURRENT   2'h0
`define BFS_SCH_POSITION  2'h1
`define BFS_SCH_BOTH      2'h2

// Trigger modes.
`define BFS_TRG_ALL       2'h0
`define BFS_TRG_EXTERNAL  2'h1
`define BFS_TRG_CURRENT   2'h2
`define BFS_TRG_NONE      2'h3

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define BFS_CTRL_RST      8'hE1
`define BFS_TIME_RST      16'h0064
`define BFS_THRESH_RST    16'h0100
`define BFS_MASK_RST      3'h0

// Interrupt status bits.
`define BFS_IRQ_TRIP      0
`define BFS_IRQ_REJECT    1
`define BFS_IRQ_START     2

// ----------------------------------------------------------------------------
// Time base: one tick per millisecond at 50 MHz.
// ----------------------------------------------------------------------------
`define BFS_CLK_HZ        50000000
`define BFS_TICK_US       1000
`define BFS_TICK_CYCLES   ((`BFS_CLK_HZ / 1000000) * `BFS_TICK_US)

`endif

// ### rtl/bfs_tick_gen.v
`timescale 1ns/1ps
`include "bfs_defines.vh"

module bfs_tick_gen (
    input  wire clk_i,   // System clock.
    input  wire rst_i,   // Synchronous reset, active high.
    output reg  tick_o   // One-cycle time-base pulse.
);

    // The divider count is cut to the counter width on purpose.
    localparam integer TICK_LAST_INT = `BFS_TICK_CYCLES - 1;
    localparam [15:0]  TICK_LAST     = TICK_LAST_INT[15:0];

    reg [15:0] div_r;

    // Divider producing one enable pulse every tick period.
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_r  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (div_r == TICK_LAST) begin
            div_r  <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            div_r  <= div_r + 16'h0001;
            tick_o <= 1'b0;
        end
    end

endmodule // bfs_tick_gen

// ### rtl/bfs_wb_regs.v
`timescale 1ns/1ps
`include "bfs_defines.vh"

module bfs_wb_regs (
    input  wire        clk_i,        // System clock.
    input  wire        rst_i,        // Synchronous reset, active high.
    input  wire [7:0]  adr_i,        // Byte address.
    input  wire [31:0] dat_i,        // Write data.
    input  wire [3:0]  sel_i,        // Byte selects.
    input  wire        we_i,         // Write enable.
    input  wire        cyc_i,        // Bus cycle.
    input  wire        stb_i,        // Strobe.
    output reg  [31:0] dat_o,        // Read data.
    output reg         ack_o,        // Acknowledge.
    input  wire [31:0] status_i,     // Live status word.
    input  wire [2:0]  irq_stat_i,   // Sticky interrupt status.
    output reg  [7:0]  ctrl_o,       // Control register.
    output reg  [15:0] time_o,       // Supervision time in ticks.
    output reg  [15:0] thresh_o,     // Current threshold.
    output reg  [2:0]  mask_o,       // Interrupt mask.
    output wire        stat_rd_o,    // Status read pulse, clears events.
    output wire        ack_wr_o      // Lock acknowledge pulse.
);

    wire access = cyc_i & stb_i & ~ack_o;
    wire wr     = access & we_i;

    assign stat_rd_o = access & ~we_i & (adr_i == `BFS_OFS_IRQ_STAT);
    assign ack_wr_o  = wr & (adr_i == `BFS_OFS_ACK) & sel_i[0] & dat_i[0];

    // Ack one cycle after the request, drop it the next cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= access;
        end
    end

    // Writable registers, byte lanes honoured.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_o   <= `BFS_CTRL_RST;
            time_o   <= `BFS_TIME_RST;
            thresh_o <= `BFS_THRESH_RST;
            mask_o   <= `BFS_MASK_RST;
        end else if (wr) begin
            case (adr_i)
                `BFS_OFS_CTRL: begin
                    if (sel_i[0]) ctrl_o <= dat_i[7:0];
                end
                `BFS_OFS_TIME: begin
                    if (sel_i[0]) time_o[7:0]  <= dat_i[7:0];
                    if (sel_i[1]) time_o[15:8] <= dat_i[15:8];
                end
                `BFS_OFS_THRESH: begin
                    if (sel_i[0]) thresh_o[7:0]  <= dat_i[7:0];
                    if (sel_i[1]) thresh_o[15:8] <= dat_i[15:8];
                end
                `BFS_OFS_IRQ_MASK: begin
                    if (sel_i[0]) mask_o <= dat_i[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data registered with the ack; unmapped reads give zero.
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (access & ~we_i) begin
            case (adr_i)
                `BFS_OFS_CTRL:     dat_o <= {24'h000000, ctrl_o};
                `BFS_OFS_TIME:     dat_o <= {16'h0000, time_o};
                `BFS_OFS_THRESH:   dat_o <= {16'h0000, thresh_o};
                `BFS_OFS_STATUS:   dat_o <= status_i;
                `BFS_OFS_IRQ_STAT: dat_o <= {29'h0000000, irq_stat_i};
                `BFS_OFS_IRQ_MASK: dat_o <= {29'h0000000, mask_o};
                default:           dat_o <= 32'h00000000;
            endcase
        end
    end

endmodule // bfs_wb_regs

// ### rtl/bfs_breaker_failure_unit.v
// How it works
// [RULE1] A selected trigger starts the timer; it keeps running after the trigger drops.
// [RULE2] Timer reaching set time before opening is seen raises the backup trip.
// [RULE3] Detected opening stops the timer, per current, position or combined scheme.
// [RULE4] Opening detected while a trigger is still active enters the rejected state.
// [RULE5] Rejected state holds, no restart, until every trigger has dropped.
// [RULE6] When triggers drop the unit returns to stand-by.
// [RULE7] Lock output rises in the same cycle as the backup trip.
// [RULE8] Lock stays set until operator acknowledge; only acknowledge clears it.
// [RULE9] Three extra trigger inputs start supervision regardless of breaker assignment.
// [RULE10] All-trips mode: any breaker-assigned trip starts supervision.
// [RULE11] External-trips mode: only assigned external trips start supervision.
// [RULE12] Current-trips mode: only assigned current-protection trips start supervision.
// [RULE13] Unassigned mode: only the extra trigger inputs start supervision.
// [RULE14] Current scheme: current below threshold counts as breaker opened.
// [RULE15] Current scheme: failure when current still above threshold at expiry.
// [RULE16] Position scheme: failure when position never showed open by expiry.
// [RULE17] Combined scheme: failure only if current high and position not open.
// [RULE18] Supervision time is counted in ticks of a fixed internal time base.
`timescale 1ns/1ps
`include "bfs_defines.vh"

module bfs_breaker_failure_unit (
    input  wire        clk_i,            // System clock, 50 MHz.
    input  wire        rst_i,            // Synchronous reset, active high.
    input  wire [7:0]  wb_adr_i,         // Wishbone byte address.
    input  wire [31:0] wb_dat_i,         // Wishbone write data.
    input  wire [3:0]  wb_sel_i,         // Wishbone byte selects.
    input  wire        wb_we_i,          // Wishbone write enable.
    input  wire        wb_cyc_i,         // Wishbone cycle.
    input  wire        wb_stb_i,         // Wishbone strobe.
    output wire [31:0] wb_dat_o,         // Wishbone read data.
    output wire        wb_ack_o,         // Wishbone acknowledge.
    input  wire        trip_ext_i,       // Assigned external trip, active high.
    input  wire        trip_cur_i,       // Assigned current-protection trip.
    input  wire        trip_oth_i,       // Any other assigned trip.
    input  wire        extra_trigger_input_a_i, // Extra assignable trigger A.
    input  wire        extra_trigger_input_b_i, // Extra assignable trigger B.
    input  wire        extra_trigger_input_c_i, // Extra assignable trigger C.
    input  wire [15:0] current_i,        // Measured current magnitude.
    input  wire        pos_open_i,       // Position inputs show breaker open.
    input  wire        operator_panel_ack_i, // Operator acknowledge pulse.
    output reg         backup_trip_o,    // Trip for the upstream breaker.
    output reg         lock_o,           // Closing inhibit, latched.
    output wire        irq_o             // Level interrupt.
);

    // ------------------------------------------------------------------------
    // States.
    // ------------------------------------------------------------------------
    localparam [3:0] ST_STANDBY  = 4'h1;
    localparam [3:0] ST_RUNNING  = 4'h2;
    localparam [3:0] ST_TRIPPED  = 4'h4;
    localparam [3:0] ST_REJECTED = 4'h8;

    wire        tick;
    wire [7:0]  ctrl;
    wire [15:0] sup_time;
    wire [15:0] thresh;
    wire [2:0]  mask;
    wire        stat_rd;
    wire        sw_ack;
    wire [31:0] status_word;

    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg  [15:0] count_r;
    reg  [2:0]  irq_stat_r;

    // ------------------------------------------------------------------------
    // Submodules.
    // ------------------------------------------------------------------------

    // Time-base enable.
    bfs_tick_gen u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // Register file.
    bfs_wb_regs u_regs (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .adr_i      (wb_adr_i),
        .dat_i      (wb_dat_i),
        .sel_i      (wb_sel_i),
        .we_i       (wb_we_i),
        .cyc_i      (wb_cyc_i),
        .stb_i      (wb_stb_i),
        .dat_o      (wb_dat_o),
        .ack_o      (wb_ack_o),
        .status_i   (status_word),
        .irq_stat_i (irq_stat_r),
        .ctrl_o     (ctrl),
        .time_o     (sup_time),
        .thresh_o   (thresh),
        .mask_o     (mask),
        .stat_rd_o  (stat_rd),
        .ack_wr_o   (sw_ack)
    );

    // ------------------------------------------------------------------------
    // Trigger selection.
    // ------------------------------------------------------------------------
    wire       enable = ctrl[`BFS_CTRL_ENABLE];
    wire [1:0] scheme = ctrl[`BFS_CTRL_SCH_HI:`BFS_CTRL_SCH_LO];
    wire [1:0] tmode  = ctrl[`BFS_CTRL_TRG_HI:`BFS_CTRL_TRG_LO];
    wire [2:0] xen    = ctrl[`BFS_CTRL_XEN_HI:`BFS_CTRL_XEN_LO];

    reg assigned_trig;

    // Breaker-assigned trips admitted by the trigger mode.
    always @* begin
        case (tmode)
            `BFS_TRG_ALL:      assigned_trig = trip_ext_i | trip_cur_i | trip_oth_i; // [RULE10]
            `BFS_TRG_EXTERNAL: assigned_trig = trip_ext_i;                           // [RULE11]
            `BFS_TRG_CURRENT:  assigned_trig = trip_cur_i;                           // [RULE12]
            default:           assigned_trig = 1'b0;                                 // [RULE13]
        endcase
    end

    // Extra inputs bypass the assignment filter.
    wire extra_trig = |(xen & {extra_trigger_input_c_i,
                               extra_trigger_input_b_i,
                               extra_trigger_input_a_i}); // [RULE9]

    wire trig = enable & (assigned_trig | extra_trig);

    // ------------------------------------------------------------------------
    // Opening detection.
    // ------------------------------------------------------------------------
    wire cur_low = (current_i < thresh); // [RULE14]
    reg  opened;

    // Opening seen according to the scheme; combined needs both to fail.
    always @* begin
        case (scheme)
            `BFS_SCH_CURRENT:  opened = cur_low;              // [RULE15]
            `BFS_SCH_POSITION: opened = pos_open_i;           // [RULE16]
            `BFS_SCH_BOTH:     opened = cur_low | pos_open_i; // [RULE17]
            default:           opened = cur_low;
        endcase
    end

    // Expiry when the tick count reaches the set time.
    wire expired = (count_r >= sup_time); // [RULE18]

    // ------------------------------------------------------------------------
    // State machine.
    // ------------------------------------------------------------------------

    // Next state from triggers, opening detection and expiry.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_STANDBY: begin
                if (trig) state_nxt = ST_RUNNING; // [RULE1]
            end
            ST_RUNNING: begin
                if (opened) begin
                    state_nxt = trig ? ST_REJECTED : ST_STANDBY; // [RULE3] [RULE4]
                end else if (expired) begin
                    state_nxt = ST_TRIPPED; // [RULE2]
                end
            end
            ST_TRIPPED: begin
                if (!trig) state_nxt = ST_STANDBY; // [RULE6]
            end
            ST_REJECTED: begin
                if (!trig) state_nxt = ST_STANDBY; // [RULE5] [RULE6]
            end
            default: state_nxt = ST_STANDBY;
        endcase
    end

    // State register and tick counter; the counter runs only while running.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_STANDBY;
            count_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            if (state_r != ST_RUNNING) begin
                count_r <= 16'h0000;
            end else if (tick && !expired) begin
                count_r <= count_r + 16'h0001; // [RULE1] [RULE18]
            end
        end
    end

    wire go_trip   = (state_r == ST_RUNNING) && (state_nxt == ST_TRIPPED);
    wire go_reject = (state_r == ST_RUNNING) && (state_nxt == ST_REJECTED);
    wire go_start  = (state_r == ST_STANDBY) && (state_nxt == ST_RUNNING);

    // ------------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------------

    // Backup trip held while tripped; lock set with it, cleared only by ack.
    always @(posedge clk_i) begin
        if (rst_i) begin
            backup_trip_o <= 1'b0;
            lock_o        <= 1'b0;
        end else begin
            backup_trip_o <= (state_nxt == ST_TRIPPED); // [RULE2]
            if (go_trip) begin
                lock_o <= 1'b1; // [RULE7]
            end else if (operator_panel_ack_i || sw_ack) begin
                lock_o <= 1'b0; // [RULE8]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts.
    // ------------------------------------------------------------------------
    wire [2:0] events;
    assign events[`BFS_IRQ_TRIP]   = go_trip;
    assign events[`BFS_IRQ_REJECT] = go_reject;
    assign events[`BFS_IRQ_START]  = go_start;

    // Sticky event bits; a status read clears them, a new event wins.
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= 3'h0;
        end else begin
            irq_stat_r <= (stat_rd ? 3'h0 : irq_stat_r) | events;
        end
    end

    assign irq_o = |(irq_stat_r & mask);

    // Live status word for software.
    assign status_word = {count_r, 8'h00, state_r,
                          cur_low, trig, lock_o, backup_trip_o};

endmodule // bfs_breaker_failure_unit

// ### bench/bfs_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker for the breaker failure unit.
// ----------------------------------------------------------------------------
module bfs_props_chk (
    input wire        clk_i,                   // System clock.
    input wire        rst_i,                   // Synchronous reset.
    input wire [7:0]  wb_adr_i,                // Bus address.
    input wire [31:0] wb_dat_i,                // Bus write data.
    input wire [3:0]  wb_sel_i,                // Bus byte selects.
    input wire        wb_we_i,                 // Bus write enable.
    input wire        wb_cyc_i,                // Bus cycle.
    input wire        wb_stb_i,                // Bus strobe.
    input wire [31:0] wb_dat_o,                // Bus read data.
    input wire        wb_ack_o,                // Bus acknowledge.
    input wire        trip_ext_i,              // External trip.
    input wire        trip_cur_i,              // Current trip.
    input wire        trip_oth_i,              // Other trip.
    input wire        extra_trigger_input_a_i, // Extra trigger A.
    input wire        extra_trigger_input_b_i, // Extra trigger B.
    input wire        extra_trigger_input_c_i, // Extra trigger C.
    input wire        operator_panel_ack_i,    // Operator acknowledge.
    input wire        backup_trip_o,           // Backup trip.
    input wire        lock_o                   // Closing inhibit.
);
    // Any trigger line high, and a software acknowledge in progress.
    wire any_trg = trip_ext_i | trip_cur_i | trip_oth_i | extra_trigger_input_a_i
                 | extra_trigger_input_b_i | extra_trigger_input_c_i;
    wire sw_ack  = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == 8'h18);

    // Shadow of the control byte, so that only the lines the mode admits count as triggers.
    reg [7:0] ctrl_sh;
    always @(posedge clk_i) begin
        if (rst_i)
            ctrl_sh <= 8'hE1;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0])
            ctrl_sh <= wb_dat_i[7:0];
    end
    wire sel_asg = (ctrl_sh[4:3] == 2'h0) ? (trip_ext_i | trip_cur_i | trip_oth_i)
                 : (ctrl_sh[4:3] == 2'h1) ? trip_ext_i
                 : (ctrl_sh[4:3] == 2'h2) ? trip_cur_i : 1'b0;
    wire sel_trg = ctrl_sh[0] & (sel_asg | (|(ctrl_sh[7:5] & {extra_trigger_input_c_i,
                   extra_trigger_input_b_i, extra_trigger_input_a_i})));

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_lock_with_trip: assert property ($rose(backup_trip_o) |-> lock_o) else $error("lock late");
    a_lock_cause: assert property ($rose(lock_o) |-> backup_trip_o) else $error("lock without trip");
    a_lock_holds: assert property (lock_o && !operator_panel_ack_i && !sw_ack |=> lock_o)
        else $error("lock dropped without acknowledge");
    a_ack_clears: assert property (operator_panel_ack_i && !backup_trip_o |=> !lock_o || backup_trip_o)
        else $error("acknowledge ignored");
    a_trip_holds: assert property (backup_trip_o && sel_trg |=> backup_trip_o)
        else $error("backup trip dropped");
    a_trip_release: assert property (backup_trip_o && !any_trg |=> !backup_trip_o)
        else $error("no return to stand-by");
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h1C
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule // bfs_props_chk

bind bfs_breaker_failure_unit bfs_props_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trip_ext_i(trip_ext_i), .trip_cur_i(trip_cur_i), .trip_oth_i(trip_oth_i),
    .extra_trigger_input_a_i(extra_trigger_input_a_i), .extra_trigger_input_b_i(extra_trigger_input_b_i),
    .extra_trigger_input_c_i(extra_trigger_input_c_i), .operator_panel_ack_i(operator_panel_ack_i),
    .backup_trip_o(backup_trip_o), .lock_o(lock_o));

// ### bench/bfs_trip_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Protection trip logic, breaker position and operator panel.
// ----------------------------------------------------------------------------
module bfs_trip_model (
    input  wire        clk_i,     // System clock.
    input  wire [5:0]  trg_req_i, // Wanted triggers {ext,cur,oth,a,b,c}.
    input  wire        cur_hi_i,  // Current above threshold wanted.
    input  wire        open_i,    // Position open wanted.
    input  wire        ack_req_i, // Operator acknowledge wanted.
    output reg  [5:0]  trg_o,     // Trigger lines.
    output reg  [15:0] current_o, // Current magnitude.
    output reg         pos_open_o,// Position shows open.
    output reg         ack_o      // Operator acknowledge.
);
    // Outputs change only after a clock edge; current sits far from the threshold.
    always @(posedge clk_i) begin
        trg_o      <= trg_req_i;
        current_o  <= cur_hi_i ? 16'h8000 : 16'h0010;
        pos_open_o <= open_i;
        ack_o      <= ack_req_i;
    end
endmodule // bfs_trip_model

// ### bench/tb_bfs_breaker_failure_unit.sv
`timescale 1ns/1ps
module tb_bfs_breaker_failure_unit;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [7:0]  adr = 8'h00;
    reg  [31:0] wdat = 32'h0;
    reg         we = 1'b0, cyc = 1'b0, stb = 1'b0;
    reg  [5:0]  trg_req = 6'h00;
    reg         cur_hi = 1'b1, open_r = 1'b0, ack_req = 1'b0;
    wire [5:0]  trg;
    wire [15:0] cur;
    wire        pos, opk, bt, lk, irq, ack;
    wire [31:0] rdat;
    integer     error_cnt = 0, n_checks = 0, i, n;
    reg  [31:0] q;
    // Row layout: ctrl[16:9], triggers {ext,cur,oth,a,b,c}[8:3], current high, open, lock expected.
    reg  [16:0] rows [0:17] = '{17'h1C305, 17'h1C285, 17'h1C245, 17'h1D305, 17'h1D284, 17'h1D244,
        17'h1E285, 17'h1E304, 17'h1F3C4, 17'h1F225, 17'h1F215, 17'h1F20D, 17'h1C300, 17'h1C701,
        17'h1C706, 17'h1CB00, 17'h1CB06, 17'h1CB05};

    // Clock of 20 ns.
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    bfs_trip_model u_model (.clk_i(clk_i), .trg_req_i(trg_req), .cur_hi_i(cur_hi), .open_i(open_r),
        .ack_req_i(ack_req), .trg_o(trg), .current_o(cur), .pos_open_o(pos), .ack_o(opk));

    bfs_breaker_failure_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .trip_ext_i(trg[5]), .trip_cur_i(trg[4]), .trip_oth_i(trg[3]), .extra_trigger_input_a_i(trg[2]),
        .extra_trigger_input_b_i(trg[1]), .extra_trigger_input_c_i(trg[0]), .current_i(cur),
        .pos_open_i(pos), .operator_panel_ack_i(opk), .backup_trip_o(bt), .lock_o(lk), .irq_o(irq));

    // Verdict and end of run.
    task final_report;
        begin
            $display("Checks: %0d, mismatches: %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // Compares a seen value with the expected one.
    task chk(input string name, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task idle(input integer k);
        begin
            repeat (k) @(posedge clk_i);
        end
    endtask

    // One classic bus cycle; read data lands in q at the acknowledge edge.
    task wb(input [7:0] a, input w, input [31:0] d);
        begin
            @(posedge clk_i);
            cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; wdat <= d;
            n = 0;
            @(posedge clk_i);
            while (ack !== 1'b1 && n < 50) begin
                @(posedge clk_i);
                n = n + 1;
            end
            q = rdat;
            cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
            if (n >= 50) error_cnt = error_cnt + 1;
        end
    endtask

    // Pulsed trigger under one setting, then operator acknowledge.
    task run_row(input [16:0] r);
        begin
            wb(8'h00, 1'b1, {24'h0, r[16:9]});
            cur_hi <= r[2]; open_r <= r[1];
            idle(3);
            trg_req <= r[8:3];
            idle(1);
            trg_req <= 6'h00;
            idle(8);
            chk("lock", lk, r[0]);
            ack_req <= 1'b1;
            idle(1);
            ack_req <= 1'b0;
            idle(3);
            chk("lock_clear", lk, 32'h0);
        end
    endtask

    // Watchdog.
    initial begin
        #(70000 * 20);
        error_cnt = error_cnt + 1;
        final_report;
    end

    // Main sequence.
    initial begin
        idle(16);
        rst_i <= 1'b0;
        chk("lock_rst", {bt, lk, irq}, 32'h0);
        wb(8'h00, 1'b0, 32'h0); chk("ctrl", q, 32'hE1);
        wb(8'h04, 1'b0, 32'h0); chk("time", q, 32'h64);
        wb(8'h08, 1'b0, 32'h0); chk("thresh", q, 32'h100);
        wb(8'h14, 1'b0, 32'h0); chk("mask", q, 32'h0);
        wb(8'h1C, 1'b0, 32'h0); chk("unmapped", q, 32'h0);
        wb(8'h04, 1'b1, 32'h0);
        for (i = 0; i < 18; i = i + 1) run_row(rows[i]);
        chk("irq_masked", irq, 32'h0);
        // Opening seen with a trigger still high.
        wb(8'h00, 1'b1, 32'hE1);
        cur_hi <= 1'b0; open_r <= 1'b0; trg_req <= 6'h20;
        idle(6);
        wb(8'h0C, 1'b0, 32'h0); chk("state_rej", q[7:4], 32'h8);
        cur_hi <= 1'b1;
        idle(6);
        chk("lock_rej", lk, 32'h0);
        wb(8'h0C, 1'b0, 32'h0); chk("state_hold", q[7:4], 32'h8);
        trg_req <= 6'h00;
        idle(4);
        wb(8'h0C, 1'b0, 32'h0); chk("state_sb", q[7:4], 32'h1);
        // Held trigger, interrupt and software acknowledge.
        wb(8'h10, 1'b0, 32'h0);
        wb(8'h14, 1'b1, 32'h1);
        trg_req <= 6'h20;
        idle(6);
        chk("trip_held", bt, 32'h1);
        chk("lock_set", lk, 32'h1);
        chk("irq_set", irq, 32'h1);
        trg_req <= 6'h00;
        idle(4);
        chk("trip_drop", bt, 32'h0);
        chk("lock_kept", lk, 32'h1);
        wb(8'h10, 1'b0, 32'h0); chk("irq_stat", q[0], 32'h1);
        idle(1);
        chk("irq_clear", irq, 32'h0);
        wb(8'h18, 1'b1, 32'h1);
        idle(1);
        chk("lock_sw", lk, 32'h0);
        // One tick of supervision time after a short trigger pulse.
        wb(8'h04, 1'b1, 32'h1);
        trg_req <= 6'h20;
        idle(1);
        trg_req <= 6'h00;
        n = 0;
        while (lk !== 1'b1 && n < 50100) begin
            @(posedge clk_i);
            n = n + 1;
        end
        chk("tick_time", (n >= 4 && n <= 50003), 32'h1);
        // Reset in mid-run drops the outputs and restores the settings.
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        chk("lock_rst2", {bt, lk, irq}, 32'h0);
        wb(8'h04, 1'b0, 32'h0); chk("time_rst2", q, 32'h64);
        final_report;
    end
endmodule // tb_bfs_breaker_failure_unit
